// ===== adc_pkg.sv
// Shared constants and types for the converter serial readout block
package adc_pkg;

  // ****************************************************************
  // Data widths
  // ****************************************************************
  localparam int DATA_W = 18;
  localparam int CFG_W = 16;
  localparam int CNT_W = 5;
  localparam int CTRL_W = 12;
  localparam int ADDR_W = 8;
  localparam int BUF_DEPTH = 2;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CONFIG_OFS = 8'h00;
  localparam logic [7:0] REG_CONTROL_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS = 8'h08;
  localparam logic [7:0] REG_RESULT_OFS = 8'h0C;

  // ****************************************************************
  // Configuration word layout
  // ****************************************************************
  localparam int CFG_TURBO_BIT = 1;
  localparam int CFG_HIGHZ_BIT = 2;
  localparam int CFG_SPAN_BIT = 3;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0] CFG_WRITE_CMD = 8'hA5;

  // ****************************************************************
  // Status register layout
  // ****************************************************************
  localparam int ST_CONVERTING_BIT = 0;
  localparam int ST_CHAIN_BIT = 1;
  localparam int ST_BUSY_ARM_BIT = 2;
  localparam int ST_SHIFT_FULL_BIT = 3;
  localparam int ST_BUF_VALID_BIT = 4;
  localparam int ST_OVERRUN_BIT = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 300;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] CTRL_RESET = CONV_CYCLES[11:0];

  // ****************************************************************
  // Conversion sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_DELIVER = 3'b100
  } conv_state_t;

endpackage

// ===== stream_if.sv
// Valid/ready word carrier between converter, buffer and shifter
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int W = 18);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== word_buffer.sv
// Small valid/ready FIFO between converter and output shifter
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
  parameter int W = 18,
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  stream_if.sink in_s,
  stream_if.source out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign in_s.ready = (count_q != (PW+1)'(DEPTH));
  assign out_s.valid = (count_q != '0);
  assign out_s.data = mem[rd_ptr_q];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == (PW)'(DEPTH - 1)) ? '0 : p + (PW)'(1);
  endfunction

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_s.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + (PW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (PW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== adc_serial_readout.sv
// Serial readout, mode selection and configuration port of the converter
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Convert rise starts conversion, latches mode
// - Input sampled at convert rising edge
// - Serial input low: daisy-chain mode
// - Serial input high: select-line mode
// - Select-line: output driven while convert low
// - Select-line: either input low enables output
// - Select-line: low at finish arms busy indicator
// - Selected: result shifts out on shift clock
// - Chain mode: data read while convert high
// - Chain mode: serial input feeds upstream data
// - Chain mode: input reappears after eighteen clocks
// - Convert low: 16-bit config on rising edges
// - Conversion timed internally, no shift clock
// - Completion delivers code and busy indication
// - High-impedance mode set by config bit
module adc_serial_readout #(
  parameter int DATA_W = adc_pkg::DATA_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convert_strobe,
  input wire logic serial_in_pin,
  input wire logic shift_clk_pin,
  input wire logic [DATA_W-1:0] analog_code,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic busy_flag,
  output logic high_z_en,
  output logic turbo_en,
  output logic span_comp_en
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit 2 convert strobe, bit 1 serial input, bit 0 shift clock
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [2:0] pin_prev_q;
  logic cnv_s;
  logic sdi_s;
  logic cnv_rise;
  logic sck_rise;
  logic sck_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      pin_prev_q <= 3'h0;
    end else begin
      pin_meta_q <= {convert_strobe, serial_in_pin, shift_clk_pin};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign cnv_s = pin_sync_q[2];
  assign sdi_s = pin_sync_q[1];
  assign cnv_rise = pin_sync_q[2] & ~pin_prev_q[2];
  assign sck_rise = pin_sync_q[0] & ~pin_prev_q[0];
  assign sck_fall = ~pin_sync_q[0] & pin_prev_q[0];

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [15:0] config_q;
  logic [11:0] ctrl_conv_q;
  logic [DATA_W-1:0] last_result_q;
  logic overrun_q;
  logic apb_write;
  logic cfg_commit;
  logic [15:0] cfg_word;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  adc_pkg::conv_state_t state_q;
  logic [11:0] conv_cnt_q;
  logic [DATA_W-1:0] sample_q;
  logic chain_mode_q;
  logic busy_arm_q;

  stream_if #(.W(DATA_W)) conv_s ();
  stream_if #(.W(DATA_W)) shift_s ();

  // Result offered to the buffer until it is accepted
  assign conv_s.valid = (state_q == adc_pkg::ST_DELIVER);
  assign conv_s.data = sample_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adc_pkg::ST_IDLE;
      conv_cnt_q <= 12'h000;
      sample_q <= '0;
      chain_mode_q <= 1'b0;
      busy_arm_q <= 1'b0;
    end else begin
      unique case (state_q)
        adc_pkg::ST_IDLE: begin
          if (cnv_rise) begin
            state_q <= adc_pkg::ST_CONVERT;
            conv_cnt_q <= ctrl_conv_q;
            sample_q <= analog_code;
            chain_mode_q <= ~sdi_s;
            busy_arm_q <= 1'b0;
          end
        end
        adc_pkg::ST_CONVERT: begin
          // Internal count only, so a stopped shift clock cannot stall it
          if (conv_cnt_q <= 12'h001) begin
            state_q <= adc_pkg::ST_DELIVER;
            busy_arm_q <= ~chain_mode_q & (~cnv_s | ~sdi_s);
          end else begin
            conv_cnt_q <= conv_cnt_q - 12'h001;
          end
        end
        adc_pkg::ST_DELIVER: begin
          // Full buffer holds the sequencer here: no word is lost
          if (conv_s.ready) begin
            state_q <= adc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  word_buffer #(.W(DATA_W), .DEPTH(adc_pkg::BUF_DEPTH)) u_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .in_s(conv_s),
    .out_s(shift_s)
  );

  // ****************************************************************
  // Output shifter
  // ****************************************************************
  logic [DATA_W-1:0] shift_q;
  logic shift_full_q;
  logic [adc_pkg::CNT_W-1:0] bit_cnt_q;
  logic sdi_cap_q;
  logic lead_low_q;
  logic selected;
  logic load;

  // Select-line: either pin low; chain: convert high
  assign selected = chain_mode_q ? cnv_s : (~cnv_s | ~sdi_s);
  assign shift_s.ready = ~shift_full_q;
  assign load = shift_s.valid & ~shift_full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      shift_full_q <= 1'b0;
      bit_cnt_q <= '0;
      sdi_cap_q <= 1'b0;
      lead_low_q <= 1'b0;
    end else if (load) begin
      shift_q <= shift_s.data;
      shift_full_q <= 1'b1;
      bit_cnt_q <= '0;
      lead_low_q <= busy_arm_q;
    end else if (selected) begin
      if (sck_rise) begin
        sdi_cap_q <= sdi_s;
      end
      if (sck_fall) begin
        if (lead_low_q) begin
          lead_low_q <= 1'b0;
        end else begin
          // Upstream bit enters at the bottom, leaves at the top
          shift_q <= {shift_q[DATA_W-2:0], chain_mode_q & sdi_cap_q};
          if (bit_cnt_q == (adc_pkg::CNT_W)'(DATA_W - 1)) begin
            shift_full_q <= 1'b0;
          end
          if (bit_cnt_q != (adc_pkg::CNT_W)'(DATA_W)) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic sdo_d;

  always_comb begin
    if (lead_low_q) begin
      sdo_d = 1'b0;
    end else if (!chain_mode_q && state_q == adc_pkg::ST_CONVERT) begin
      sdo_d = 1'b1;
    end else begin
      sdo_d = shift_q[DATA_W-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
      busy_flag <= 1'b0;
    end else begin
      serial_out_pin <= sdo_d;
      serial_out_oe <= selected;
      busy_flag <= (state_q == adc_pkg::ST_CONVERT);
    end
  end

  // ****************************************************************
  // Serial configuration port
  // ****************************************************************
  logic [15:0] cfg_shift_q;
  logic [adc_pkg::CNT_W-1:0] cfg_cnt_q;

  assign cfg_word = {cfg_shift_q[14:0], sdi_s};
  // Command byte guards against readout clocks writing the config
  assign cfg_commit = ~cnv_s & sck_rise & (cfg_cnt_q == (adc_pkg::CNT_W)'(adc_pkg::CFG_W - 1))
                      & (cfg_word[15:8] == adc_pkg::CFG_WRITE_CMD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_shift_q <= 16'h0000;
      cfg_cnt_q <= '0;
    end else if (cnv_s) begin
      cfg_cnt_q <= '0;
    end else if (sck_rise && cfg_cnt_q != (adc_pkg::CNT_W)'(adc_pkg::CFG_W)) begin
      cfg_shift_q <= cfg_word;
      cfg_cnt_q <= cfg_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_z_en <= 1'b0;
      turbo_en <= 1'b0;
      span_comp_en <= 1'b0;
    end else begin
      high_z_en <= config_q[adc_pkg::CFG_HIGHZ_BIT];
      turbo_en <= config_q[adc_pkg::CFG_TURBO_BIT];
      span_comp_en <= config_q[adc_pkg::CFG_SPAN_BIT];
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == adc_pkg::REG_CONFIG_OFS) || (a == adc_pkg::REG_CONTROL_OFS)
               || (a == adc_pkg::REG_STATUS_OFS) || (a == adc_pkg::REG_RESULT_OFS);
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    read_mux = 32'h0000_0000;
    if (a == adc_pkg::REG_CONFIG_OFS) begin
      read_mux[15:0] = config_q;
    end else if (a == adc_pkg::REG_CONTROL_OFS) begin
      read_mux[11:0] = ctrl_conv_q;
    end else if (a == adc_pkg::REG_STATUS_OFS) begin
      read_mux[adc_pkg::ST_CONVERTING_BIT] = (state_q == adc_pkg::ST_CONVERT);
      read_mux[adc_pkg::ST_CHAIN_BIT] = chain_mode_q;
      read_mux[adc_pkg::ST_BUSY_ARM_BIT] = busy_arm_q;
      read_mux[adc_pkg::ST_SHIFT_FULL_BIT] = shift_full_q;
      read_mux[adc_pkg::ST_BUF_VALID_BIT] = shift_s.valid;
      read_mux[adc_pkg::ST_OVERRUN_BIT] = overrun_q;
    end else if (a == adc_pkg::REG_RESULT_OFS) begin
      read_mux[DATA_W-1:0] = last_result_q;
    end
  endfunction

  assign apb_write = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // No wait state: answer prepared in the setup cycle
      pready <= psel & ~penable;
      // Error only stands beside the ready pulse
      pslverr <= psel & ~penable & ~addr_hit(paddr);
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : read_mux(paddr);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= adc_pkg::CFG_RESET;
      ctrl_conv_q <= adc_pkg::CTRL_RESET;
    end else begin
      // Serial write wins over a same-cycle bus write
      if (cfg_commit) begin
        config_q <= cfg_word;
      end else if (apb_write && paddr == adc_pkg::REG_CONFIG_OFS) begin
        config_q <= pwdata[15:0];
      end
      if (apb_write && paddr == adc_pkg::REG_CONTROL_OFS) begin
        ctrl_conv_q <= pwdata[11:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
      last_result_q <= '0;
    end else begin
      if (cnv_rise && state_q != adc_pkg::ST_IDLE) begin
        overrun_q <= 1'b1;
      end else if (apb_write && paddr == adc_pkg::REG_STATUS_OFS
                   && pwdata[adc_pkg::ST_OVERRUN_BIT]) begin
        overrun_q <= 1'b0;
      end
      if (conv_s.valid && conv_s.ready) begin
        last_result_q <= sample_q;
      end
    end
  end

endmodule
`default_nettype wire

// ===== adc_serial_readout_checker.sv
// Port-level assertions for the converter serial readout block
`timescale 1ns/1ns
`default_nettype none
module adc_serial_readout_checker #(
  parameter int DATA_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic convert_strobe,
  input wire logic serial_in_pin,
  input wire logic serial_out_oe,
  input wire logic busy_flag
);
  logic strobe_q;
  logic chain_q;
  logic seen_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Raw pin copy of the mode; ignored rises leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b0;
      chain_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      strobe_q <= convert_strobe;
      if (convert_strobe && !strobe_q && !busy_flag) begin
        chain_q <= !serial_in_pin;
        seen_q <= 1'b1;
      end
    end
  end
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_oe_select: assert property ((seen_q && !chain_q && !convert_strobe)[*8] |-> serial_out_oe)
    else $error("select mode output not driven");
  a_oe_chain: assert property ((seen_q && chain_q && convert_strobe)[*8] |-> serial_out_oe)
    else $error("chain mode output not driven");
  a_oe_release: assert property ((seen_q && !chain_q && convert_strobe && serial_in_pin)[*8]
    |-> !serial_out_oe)
    else $error("select mode output not released");
  a_chain_low_off: assert property ((seen_q && chain_q && !convert_strobe)[*8] |-> !serial_out_oe)
    else $error("chain mode output not released");
  a_busy_start: assert property ($rose(convert_strobe) && !busy_flag |-> ##[2:6] busy_flag)
    else $error("conversion did not start");
  a_busy_bounded: assert property ($rose(busy_flag) |-> busy_flag[*8] ##[1:1000] !busy_flag)
    else $error("conversion length wrong");
endmodule
bind adc_serial_readout adc_serial_readout_checker #(.DATA_W(DATA_W)) i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .convert_strobe(convert_strobe),
  .serial_in_pin(serial_in_pin), .serial_out_oe(serial_out_oe), .busy_flag(busy_flag));
`default_nettype wire

// ===== adc_host_model.sv
// Host serial port model: frames the shift clock and swaps bits
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [5:0] nbits,
  input wire logic [35:0] tx,
  input wire logic idle_in,
  input wire logic serial_out_pin,
  output logic shift_clk_pin,
  output logic serial_in_pin,
  output logic [35:0] rx,
  output logic done
);
  logic framing;
  logic bit_q;
  // Outside a frame the bench sets the input pin level
  assign serial_in_pin = framing ? bit_q : idle_in;
  initial begin
    shift_clk_pin = 1'b0;
    framing = 1'b0;
    bit_q = 1'b0;
    rx = '0;
    done = 1'b0;
    forever begin
      @(posedge pclk);
      done <= 1'b0;
      if (go === 1'b1) begin
        framing <= 1'b1;
        rx <= '0;
        for (int i = 0; i < int'(nbits); i++) begin
          bit_q <= tx[35-i];
          repeat (8) @(posedge pclk);
          shift_clk_pin <= 1'b1;
          rx <= {rx[34:0], serial_out_pin};
          repeat (8) @(posedge pclk);
          shift_clk_pin <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        framing <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== adc_serial_readout_tb.sv
// Self-checking bench for the converter serial readout block
`timescale 1ns/1ns
`default_nettype none
module adc_serial_readout_tb;
  typedef struct packed {logic [35:0] m; logic [35:0] v;} note_t;
  localparam logic [35:0] ALL = 36'hFFFFFFFFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic strobe, idle_in, go, shclk, ser_in, ser_out, oe, busy, hz, turbo, span, done;
  logic [17:0] code, val, up;
  logic [35:0] tx, rx;
  logic [5:0] nbits;
  logic [15:0] words [2] = '{16'hA50E, 16'h5A00};
  logic sdo_line;
  note_t q[$];
  note_t e;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 96270;
  adc_serial_readout i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convert_strobe(strobe), .serial_in_pin(ser_in), .shift_clk_pin(shclk),
    .analog_code(code), .serial_out_pin(ser_out), .serial_out_oe(oe), .busy_flag(busy),
    .high_z_en(hz), .turbo_en(turbo), .span_comp_en(span));
  // No pull on the line: a released output reads inverted, so a lost enable shows
  assign sdo_line = oe ? ser_out : ~ser_out;
  adc_host_model i_host (.pclk(pclk), .go(go), .nbits(nbits), .tx(tx), .idle_in(idle_in),
    .serial_out_pin(sdo_line), .shift_clk_pin(shclk), .serial_in_pin(ser_in), .rx(rx),
    .done(done));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [35:0] m, input logic [35:0] v);
    q.push_back('{m, v});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) mismatches++;
  endtask
  task automatic frame(input logic [35:0] t, input logic [5:0] b);
    int n;
    n = 0;
    tx <= t;
    nbits <= b;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (done !== 1'b1 && n < 1000);
    if (n >= 1000) mismatches++;
  endtask
  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(posedge pclk) begin
    if ((psel && penable && pready && !pwrite) === 1'b1 || done === 1'b1) begin
      if (q.size() == 0) begin
        mismatches++;
      end else begin
        e = q.pop_front();
        check((done === 1'b1 ? rx : {3'b000, pslverr, prdata}) & e.m, e.v & e.m);
      end
    end
  end
  initial begin
    {psel, penable, pwrite, strobe, go, presetn} = '0;
    {paddr, pwdata, code, tx, nbits} = '0;
    idle_in = 1'b1;
    tick(16);
    presetn <= 1'b1;
    tick(1);
    rd(adc_pkg::REG_CONFIG_OFS, ALL, 36'h0);
    rd(adc_pkg::REG_CONTROL_OFS, ALL, 36'(adc_pkg::CTRL_RESET));
    rd(8'h10, ALL, 36'h100000000);
    apb(1'b1, adc_pkg::REG_CONTROL_OFS, 32'h28);
    rd(adc_pkg::REG_CONTROL_OFS, ALL, 36'h28);
    val = 18'($random(seed));
    code <= val;
    tick(4);
    strobe <= 1'b1;
    wait_busy(1'b1);
    code <= ~val;
    tick(8);
    check(36'(oe), 36'h0);
    idle_in <= 1'b0;
    tick(8);
    check(36'(oe), 36'h1);
    idle_in <= 1'b1;
    wait_busy(1'b0);
    strobe <= 1'b0;
    tick(8);
    check(36'(oe), 36'h1);
    q.push_back('{ALL, 36'(val)});
    frame(36'h0, 6'd18);
    rd(adc_pkg::REG_RESULT_OFS, ALL, 36'(val));
    for (int i = 0; i < 2; i++) begin
      strobe <= 1'b1;
      wait_busy(1'b1);
      wait_busy(1'b0);
      strobe <= 1'b0;
      tick(8);
      q.push_back('{36'h0, 36'h0});
      frame({words[i], 20'h0}, 6'd18);
      tick(4);
      check(36'({hz, turbo, span}), 36'h7);
    end
    idle_in <= 1'b0;
    val = 18'($random(seed));
    up = 18'($random(seed));
    code <= val;
    tick(4);
    strobe <= 1'b1;
    wait_busy(1'b1);
    code <= ~val;
    wait_busy(1'b0);
    tick(4);
    check(36'(oe), 36'h1);
    q.push_back('{ALL, {val, up}});
    frame({up, 18'h0}, 6'd36);
    strobe <= 1'b0;
    tick(8);
    check(36'(oe), 36'h0);
    idle_in <= 1'b1;
    val = 18'($random(seed));
    code <= val;
    tick(4);
    strobe <= 1'b1;
    wait_busy(1'b1);
    code <= ~val;
    strobe <= 1'b0;
    tick(4);
    strobe <= 1'b1;
    tick(4);
    strobe <= 1'b0;
    wait_busy(1'b0);
    q.push_back('{ALL, 36'(val)});
    frame(36'h0, 6'd19);
    rd(adc_pkg::REG_STATUS_OFS, 36'h24, 36'h24);
    apb(1'b1, adc_pkg::REG_STATUS_OFS, 32'h20);
    rd(adc_pkg::REG_STATUS_OFS, 36'h20, 36'h0);
    end_sim();
  end
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
